// file: design/asoi_buf2.sv
`timescale 1ns/1ps
module asoi_buf2 #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic             ref_clk,
   input  wire logic             nrst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ff;
   logic [AW-1:0]    rd_ff;
   logic [AW:0]      cnt_ff;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
      wrap_inc = (p == AW'(DEPTH-1)) ? '0 : AW'(p + 1'b1);
   endfunction

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end

   // Registered read data so the consumer sees a flop output
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         out_data <= '0;
      end else if (pop && cnt_ff > (AW+1)'(1)) begin
         out_data <= mem_ff[wrap_inc(rd_ff)];
      end else if (push && (cnt_ff == '0 || (pop && cnt_ff == (AW+1)'(1)))) begin
         out_data <= in_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wr_ff <= wrap_inc(wr_ff);
         end
         if (pop) begin
            rd_ff <= wrap_inc(rd_ff);
         end
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// file: design/asoi_top.sv
`timescale 1ns/1ps
// What this block does
// - Sample the analog input on every falling conversion clock edge while out of standby, one per cycle.
// - Drive each result on the data pins shortly after a falling clock edge.
// - Ten result bits; bit 0 is least significant, bit 9 most significant.
// - Straight unsigned binary: lowest input all zeros, highest input all ones.
// - Standby input high: low-power standby and data pins released, any enable.
// - Pins driven only when active-low enable and standby input are both low.
module asoi_top
   import asoi_pkg::*;
#(
   parameter int unsigned RES_BITS = ASOI_RES_BITS,
   parameter int unsigned LATENCY  = ASOI_PIPE_LATENCY,
   parameter int unsigned BUF_DEP  = ASOI_BUF_DEPTH
) (
   input  wire logic                ref_clk,
   input  wire logic                nrst,
   input  wire logic                conv_clk_pin,
   input  wire logic                output_enable_n_pin,
   input  wire logic                standby_request,
   input  wire logic [RES_BITS-1:0] analog_sample_input,
   output logic      [RES_BITS-1:0] result_bits,
   output logic      [RES_BITS-1:0] result_bits_oe_n,
   output logic                     result_valid_ff,
   output logic                     standby_ff,
   output logic                     overrun_ff
);
   logic [2:0]                conv_sync_ff;
   logic [1:0]                oen_sync_ff;
   logic [1:0]                sby_sync_ff;
   logic [RES_BITS-1:0]       smp_meta_ff;
   logic [RES_BITS-1:0]       smp_sync_ff;
   logic [RES_BITS-1:0]       pipe_ff [LATENCY];
   logic [LATENCY-1:0]        pipe_vld_ff;
   logic                      fall;
   logic                      buf_in_ready;
   logic                      buf_out_valid;
   logic [RES_BITS-1:0]       buf_out_data;
   logic                      take;
   logic                      running;
   logic                      push_req;
   logic                      rate_err;
   logic                      full_err;
   logic [7:0]                gap_ff;
   asoi_state_t               state_ff;
   asoi_state_t               nxt_state;

   // Pins are asynchronous to ref_clk; first stage feeds only the second
   // Clock pin: two synchroniser stages plus one history stage for the edge detector
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         conv_sync_ff <= '0;
      end else begin
         conv_sync_ff <= {conv_sync_ff[1:0], conv_clk_pin};
      end
   end

   // Controls reset to released and standby so the pins stay quiet until both are seen low
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         oen_sync_ff <= {2{ASOI_OE_RELEASED}};
         sby_sync_ff <= 2'b11;
      end else begin
         oen_sync_ff <= {oen_sync_ff[0], output_enable_n_pin};
         sby_sync_ff <= {sby_sync_ff[0], standby_request};
      end
   end

   // Bitwise sampling assumes the sample word is steady around each clock fall
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         smp_meta_ff <= '0;
         smp_sync_ff <= '0;
      end else begin
         smp_meta_ff <= analog_sample_input;
         smp_sync_ff <= smp_meta_ff;
      end
   end

   // After reset the history fills with ones from the idle-high pin, which only
   // looks like a rise, so no false sample follows reset
   assign fall    = conv_sync_ff[2] && !conv_sync_ff[1];
   assign running = (state_ff == ASOI_ST_RUN);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ASOI_ST_STANDBY: begin
            if (!sby_sync_ff[1]) begin
               nxt_state = ASOI_ST_RUN;
            end
         end
         ASOI_ST_RUN: begin
            if (sby_sync_ff[1]) begin
               nxt_state = ASOI_ST_STANDBY;
            end
         end
         default: nxt_state = ASOI_ST_STANDBY;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state_ff <= ASOI_ST_STANDBY;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Flag follows the next state so it agrees with the state register, not a cycle late
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         standby_ff <= 1'b1;
      end else begin
         standby_ff <= (nxt_state == ASOI_ST_STANDBY);
      end
   end

   // Sample pipeline advances once per falling edge; in standby the data holds and all valid flags clear
   genvar g;
   generate
      for (g = 0; g < LATENCY; g++) begin : g_pipe
         logic [RES_BITS-1:0] src;
         logic                src_vld;
         if (g == 0) begin : g_head
            assign src     = smp_sync_ff;
            assign src_vld = 1'b1;
         end else begin : g_tail
            assign src     = pipe_ff[g-1];
            assign src_vld = pipe_vld_ff[g-1];
         end
         always_ff @(posedge ref_clk) begin
            if (!nrst) begin
               pipe_ff[g]     <= '0;
               pipe_vld_ff[g] <= 1'b0;
            end else if (!running) begin
               pipe_vld_ff[g] <= 1'b0;
            end else if (fall) begin
               pipe_ff[g]     <= src;
               pipe_vld_ff[g] <= src_vld;
            end
         end
      end
   endgenerate

   // A word leaves the pipe at the fall that overwrites its last stage
   assign push_req = fall && pipe_vld_ff[LATENCY-1] && running;

   // Buffer absorbs up to BUF_DEP words while the pins are disabled; a further word is lost and flags overrun
   asoi_buf2 #(
      .WIDTH (RES_BITS),
      .DEPTH (BUF_DEP)
   ) u_buf (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .in_valid  (push_req),
      .in_ready  (buf_in_ready),
      .in_data   (pipe_ff[LATENCY-1]),
      .out_valid (buf_out_valid),
      .out_ready (take),
      .out_data  (buf_out_data)
   );

   // Drain when enabled and running; a disabled output or standby stalls the buffer
   assign take = buf_out_valid && !oen_sync_ff[1] && running;

   // The word on the pins holds until the next one is taken
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         result_bits <= ASOI_CODE_ZERO;
      end else if (take) begin
         result_bits <= buf_out_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         result_valid_ff <= 1'b0;
      end else begin
         result_valid_ff <= take;
      end
   end

   // Enables low means driven
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         result_bits_oe_n <= '1;
      end else if (sby_sync_ff[1]) begin
         result_bits_oe_n <= '1;
      end else if (oen_sync_ff[1]) begin
         result_bits_oe_n <= '1;
      end else begin
         result_bits_oe_n <= '0;
      end
   end

   // Saturating gap counter: a long idle stretch cannot wrap into a false rate error.
   // Two-flop sampling cannot resolve falls closer than two cycles apart.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         gap_ff <= '0;
      end else if (fall) begin
         gap_ff <= 8'h01;
      end else if (gap_ff != 8'hFF && gap_ff != 8'h00) begin
         gap_ff <= gap_ff + 8'h01;
      end
   end

   assign rate_err = fall && gap_ff != 8'h00 && gap_ff < 8'(ASOI_MIN_CONV_CYC);
   assign full_err = push_req && !buf_in_ready;

   // Sticky until reset so a short overrun is not missed by slow capture logic
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         overrun_ff <= 1'b0;
      end else if (rate_err || full_err) begin
         overrun_ff <= 1'b1;
      end
   end
endmodule

// file: include/asoi_pkg.sv
package asoi_pkg;
   localparam int unsigned ASOI_RES_BITS       = 10;
   localparam int unsigned ASOI_PIPE_LATENCY   = 2;
   localparam int unsigned ASOI_BUF_DEPTH      = 2;
   localparam int unsigned ASOI_MAX_RATE_KSPS  = 25000;
   localparam int unsigned ASOI_REF_CLK_KHZ    = 50000;
   // Fewest ref_clk cycles between two conversion clock falls at the top rate
   localparam int unsigned ASOI_MIN_CONV_CYC   =
      (ASOI_REF_CLK_KHZ + ASOI_MAX_RATE_KSPS - 1) / ASOI_MAX_RATE_KSPS;
   localparam logic [9:0]  ASOI_CODE_ZERO      = 10'h000;
   localparam logic [9:0]  ASOI_CODE_FULL      = 10'h3FF;
   localparam logic        ASOI_OE_RELEASED    = 1'b1;
   typedef enum logic [1:0] {ASOI_ST_STANDBY, ASOI_ST_RUN} asoi_state_t;
endpackage

// file: verif/asoi_capture_model.sv
`timescale 1ns/1ps
module asoi_capture_model (
   input  wire logic       ref_clk,
   input  wire logic [9:0] result_bits,
   input  wire logic [9:0] result_bits_oe_n,
   input  wire logic       result_valid_ff,
   output logic            conv_clk_pin
);
   logic [9:0] pins;
   logic [9:0] last_ff = 10'h000;
   int         words = 0;
   initial conv_clk_pin = 1'b1;
   // Released pins show the inverse of the last word, never a stale copy
   assign pins = (result_bits & ~result_bits_oe_n) | (~last_ff & result_bits_oe_n);
   always @(posedge ref_clk) begin
      if (result_valid_ff) begin
         words <= words + 1;
         last_ff <= pins;
      end
   end
   // Clock idles high; four ref_clk per sample stays well under the top rate
   task automatic falls(input int n);
      repeat (n) begin
         repeat (2) @(posedge ref_clk);
         #2 conv_clk_pin = 1'b0;
         repeat (2) @(posedge ref_clk);
         #2 conv_clk_pin = 1'b1;
      end
   endtask
endmodule

// file: verif/asoi_top_properties.sv
`timescale 1ns/1ps
module asoi_top_chk #(
   parameter int unsigned RES_BITS = 10,
   parameter int unsigned LATENCY  = 2,
   parameter int unsigned BUF_DEP  = 2
) (
   input wire logic                ref_clk,
   input wire logic                nrst,
   input wire logic                conv_clk_pin,
   input wire logic                output_enable_n_pin,
   input wire logic                standby_request,
   input wire logic [RES_BITS-1:0] analog_sample_input,
   input wire logic [RES_BITS-1:0] result_bits,
   input wire logic [RES_BITS-1:0] result_bits_oe_n,
   input wire logic                result_valid_ff,
   input wire logic                standby_ff,
   input wire logic                overrun_ff
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   property p_sby_float; standby_request [*4] |-> result_bits_oe_n == '1; endproperty
   a_sby_float: assert property (p_sby_float) else $error("pins driven in standby");
   property p_sby_flag; standby_request [*4] |-> standby_ff; endproperty
   a_sby_flag: assert property (p_sby_flag) else $error("standby not entered");
   property p_sby_quiet; standby_request [*5] |-> !result_valid_ff; endproperty
   a_sby_quiet: assert property (p_sby_quiet) else $error("word out in standby");
   property p_oe_float; output_enable_n_pin [*4] |-> result_bits_oe_n == '1; endproperty
   a_oe_float: assert property (p_oe_float) else $error("pins driven while disabled");
   property p_oe_drive;
      (!output_enable_n_pin && !standby_ff) [*5] |-> result_bits_oe_n == '0;
   endproperty
   a_oe_drive: assert property (p_oe_drive) else $error("pins not driven");
   property p_oe_whole; result_bits_oe_n == '0 || result_bits_oe_n == '1; endproperty
   a_oe_whole: assert property (p_oe_whole) else $error("pins split in enable");
   property p_word_hold; !$stable(result_bits) |-> result_valid_ff; endproperty
   a_word_hold: assert property (p_word_hold) else $error("word changed unannounced");
   c_word: cover property (result_valid_ff && result_bits_oe_n == '0);
   c_ovr: cover property ($rose(overrun_ff));
   c_wake: cover property ($fell(standby_ff));
   c_sleep: cover property ($rose(standby_ff));
endmodule
bind asoi_top asoi_top_chk #(.RES_BITS(RES_BITS), .LATENCY(LATENCY), .BUF_DEP(BUF_DEP)) u_chk (
   .ref_clk(ref_clk), .nrst(nrst), .conv_clk_pin(conv_clk_pin),
   .output_enable_n_pin(output_enable_n_pin), .standby_request(standby_request),
   .analog_sample_input(analog_sample_input), .result_bits(result_bits),
   .result_bits_oe_n(result_bits_oe_n), .result_valid_ff(result_valid_ff),
   .standby_ff(standby_ff), .overrun_ff(overrun_ff));

// file: verif/tb_asoi_top.sv
`timescale 1ns/1ps
module tb_asoi_top import asoi_pkg::*;;
   typedef struct packed {logic [9:0] ain; logic [9:0] res;} asoi_row_t;
   localparam asoi_row_t ROWS [6] = '{'{10'h000, 10'h000}, '{10'h3FF, 10'h3FF},
      '{10'h001, 10'h001}, '{10'h200, 10'h200}, '{10'h155, 10'h155}, '{10'h2AA, 10'h2AA}};
   logic       ref_clk = 1'b0;
   logic       nrst = 1'b0;
   logic       oe_n = 1'b1;
   logic       sby = 1'b1;
   logic [9:0] ain = 10'h000;
   logic [9:0] res;
   logic [9:0] res_oe_n;
   logic       vld, sby_ff, ovr, conv_clk;
   int         failures = 0;
   int         checked = 0;
   int         base;
   always #10 ref_clk = ~ref_clk;
   asoi_top uut (.ref_clk(ref_clk), .nrst(nrst), .conv_clk_pin(conv_clk),
      .output_enable_n_pin(oe_n), .standby_request(sby), .analog_sample_input(ain),
      .result_bits(res), .result_bits_oe_n(res_oe_n), .result_valid_ff(vld),
      .standby_ff(sby_ff), .overrun_ff(ovr));
   asoi_capture_model cap (.ref_clk(ref_clk), .result_bits(res),
      .result_bits_oe_n(res_oe_n), .result_valid_ff(vld), .conv_clk_pin(conv_clk));
   task automatic test_done;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cmp10(input logic [9:0] got, input logic [9:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_int(input int got, input int exp);
      checked++;
      if (got != exp) begin
         failures++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   initial begin
      begin : body
         step(3);
         cmp10({7'h0, sby_ff, vld, ovr}, 10'h004);
         cmp10(res, 10'h000);
         nrst = 1'b1;
         oe_n = 1'b0;
         step(6);
         cmp10(res_oe_n, 10'h3FF);
         cap.falls(4);
         step(8);
         cmp_int(cap.words, 0);
         sby = 1'b0;
         for (int i = 0; i < 20 && sby_ff !== 1'b0; i++)
            step(1);
         cmp10({9'h0, sby_ff}, 10'h000);
         if (sby_ff !== 1'b0)
            disable body;
         step(4);
         cap.falls(ASOI_PIPE_LATENCY);
         step(8);
         cmp_int(cap.words, 0);
         cap.falls(1);
         step(8);
         cmp_int(cap.words, 1);
         foreach (ROWS[i]) begin
            ain = ROWS[i].ain;
            step(4);
            base = cap.words;
            cap.falls(4);
            step(8);
            cmp10(res, ROWS[i].res);
            cmp10(cap.last_ff, ROWS[i].res);
            cmp_int(cap.words - base, 4);
         end
         // Stall: two words fit in the buffer, the third is lost
         oe_n = 1'b1;
         base = cap.words;
         cap.falls(2);
         step(8);
         cmp10({9'h0, ovr}, 10'h000);
         cap.falls(1);
         step(8);
         cmp10({9'h0, ovr}, 10'h001);
         cmp_int(cap.words - base, 0);
         cmp10(res_oe_n, 10'h3FF);
         oe_n = 1'b0;
         step(10);
         cmp_int(cap.words - base, 2);
         cmp10(res_oe_n, 10'h000);
         // Standby while running: pins float although enabled, and the pipe is flushed
         sby = 1'b1;
         step(4);
         cmp10(res_oe_n, 10'h3FF);
         cmp10({9'h0, sby_ff}, 10'h001);
         base = cap.words;
         cap.falls(2);
         step(8);
         cmp_int(cap.words - base, 0);
         sby = 1'b0;
         for (int i = 0; i < 20 && sby_ff !== 1'b0; i++)
            step(1);
         cmp10({9'h0, sby_ff}, 10'h000);
         if (sby_ff !== 1'b0)
            disable body;
         step(4);
         cap.falls(ASOI_PIPE_LATENCY);
         step(8);
         cmp_int(cap.words - base, 0);
         cap.falls(1);
         step(8);
         cmp_int(cap.words - base, 1);
         cmp10(res, 10'h2AA);
         // Reset in mid-run, then the first edges after its release
         nrst = 1'b0;
         step(2);
         cmp10({7'h0, sby_ff, vld, ovr}, 10'h004);
         cmp10(res, 10'h000);
         cmp10(res_oe_n, 10'h3FF);
         nrst = 1'b1;
         step(2);
         cmp10({7'h0, sby_ff, vld, ovr}, 10'h004);
         cmp10(res_oe_n, 10'h3FF);
         step(4);
         cmp10({9'h0, sby_ff}, 10'h000);
         cmp10(res_oe_n, 10'h000);
      end
      test_done();
   end
endmodule
